// ==== eeecr_regs.sv ====
// register bank for low-power-idle configuration and status
// Functional notes
// (RQ1) bypass bit 3 set: abilities from bit 0; clear: from capability and advertisement registers
// (RQ2) with bypass, bit 0 replaces advertisement and link-partner registers for advertisement
// (RQ3) next-page-disable bit 2 set refuses eee next pages; reset 0 allows them
// (RQ4) rx-shutdown bit 1 (reset 1) powers analog receive down in quiet state
// (RQ5) capabilities-enable bit 0, strap-loaded, negotiates per advertisement and partner registers
// (RQ6) capabilities-enable clear ignores capability and both advertisement registers
// (RQ7) pcs control bit 15 write 1 soft-resets pcs registers, then self-clears
// (RQ8) soft reset leaves vendor-specific registers unchanged
// (RQ9) pcs control bit 10 allows stopping receive clock during low-power idle
// (RQ10) status bits 11/10 latch once tx/rx pcs has received lpi
// (RQ11) status bits 9/8 show live tx/rx lpi reception
// (RQ12) status bit 6 read-only tx clock stoppable, reset 0
// (RQ13) capability bits 1 (100) and 2 (1000) read-only, reset 0
// (RQ14) 16-bit wake error counter counts wake-time faults
// (RQ15) read clears counter; it saturates at all ones
// (RQ16) pcs soft reset also clears wake error counter
// (RQ17) reserved fields read their defaults; writes to read-only fields ignored; eee_config_three stores the whole written word, reserved bits included
//
// Decided for this implementation: the address-and-strobe port.
`default_nettype none
module eeecr_regs #(
  parameter logic CAP_100_SUPPORT = 1'b0,
  parameter logic CAP_1000_SUPPORT = 1'b0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic strap_eee_en_i,
  input wire eeecr_pkg::eeecr_req_s req_i,
  input wire eeecr_pkg::eeecr_stat_s stat_i,
  output logic [eeecr_pkg::EEECR_DW-1:0] rdata_o,
  output eeecr_pkg::eeecr_ctrl_s ctrl_o,
  output logic neg_eee_100_o
);
  import eeecr_pkg::*;

  // every field position below assumes 16-bit words on the plain port
  if (EEECR_DW != 16 || EEECR_AW != 16) begin : g_bad_width
    $error("register bank needs 16-bit address and data");
  end

  logic [15:0] cfg2_ff;
  logic [15:0] cfg3_ff;
  logic strap_pending_ff;
  logic rx_clk_stop_ff;
  logic soft_rst_ff;
  logic tx_lpi_rcvd_ff;
  logic rx_lpi_rcvd_ff;
  logic adv_100_ff;
  logic [15:0] wake_cnt_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] pcs_ctrl_val;
  logic [15:0] pcs_sts_val;
  logic [15:0] cap_val;
  logic soft_rst_req;

  function automatic logic wr_hit(input eeecr_req_s r, input logic [15:0] a);
    return r.wr && (r.addr == a);
  endfunction

  assign soft_rst_req = wr_hit(req_i, ADDR_PCS_CONTROL_ONE) && req_i.wdata[PCS_RESET_BIT];

  // vendor space: untouched by pcs soft reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg2_ff <= CFG2_RESET;
    end else if (wr_hit(req_i, ADDR_EEE_CONFIG_TWO)) begin
      cfg2_ff <= (req_i.wdata & CFG2_RW_MASK) | (CFG2_RESET & ~CFG2_RW_MASK); // RQ17
    end
  end

  // strap captured on the first clock after reset release
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg3_ff <= CFG3_RESET;
      strap_pending_ff <= 1'b1;
    end else begin
      strap_pending_ff <= 1'b0;
      if (wr_hit(req_i, ADDR_EEE_CONFIG_THREE)) begin
        cfg3_ff <= req_i.wdata;
      end else if (strap_pending_ff) begin
        cfg3_ff[CFG3_CAP_EN_BIT] <= strap_eee_en_i; // RQ5
      end
    end
  end

  // soft reset is a one-cycle pulse; bit 15 is not stored and always reads back as 0
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= soft_rst_req; // RQ7
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || soft_rst_req) begin
      rx_clk_stop_ff <= PCS_CTRL_RESET[PCS_RXCLK_STOP_BIT]; // RQ7
    end else if (wr_hit(req_i, ADDR_PCS_CONTROL_ONE)) begin
      rx_clk_stop_ff <= req_i.wdata[PCS_RXCLK_STOP_BIT]; // RQ9
    end
  end

  // latched lpi-received flags; cleared by reset and by pcs soft reset
  always_ff @(posedge clk_i) begin
    if (reset_i || soft_rst_req) begin
      tx_lpi_rcvd_ff <= 1'b0;
      rx_lpi_rcvd_ff <= 1'b0;
    end else begin
      if (stat_i.tx_lpi) tx_lpi_rcvd_ff <= 1'b1; // RQ10
      if (stat_i.rx_lpi) rx_lpi_rcvd_ff <= 1'b1; // RQ10
    end
  end

  // mmd7 advertisement; cleared back to default by soft reset
  always_ff @(posedge clk_i) begin
    if (reset_i || soft_rst_req) begin
      adv_100_ff <= ADV_RESET[ADV_100_BIT];
    end else if (wr_hit(req_i, ADDR_ADV_OVERRIDE)) begin
      adv_100_ff <= req_i.wdata[ADV_100_BIT];
    end
  end

  // a fault in the same cycle as the clearing read is kept: count restarts at 1
  always_ff @(posedge clk_i) begin
    if (reset_i || soft_rst_req) begin
      wake_cnt_ff <= ZERO16; // RQ16
    end else if (req_i.rd && req_i.addr == ADDR_WAKE_ERROR_COUNT) begin
      wake_cnt_ff <= stat_i.wake_fault ? 16'h0001 : ZERO16; // RQ15
    end else if (stat_i.wake_fault && wake_cnt_ff != WAKE_CNT_MAX) begin
      wake_cnt_ff <= wake_cnt_ff + 16'h0001; // RQ14 RQ15
    end
  end

  always_comb begin
    pcs_ctrl_val = PCS_CTRL_RESET;
    pcs_ctrl_val[PCS_RXCLK_STOP_BIT] = rx_clk_stop_ff;
    pcs_sts_val = ZERO16;
    pcs_sts_val[STS_TX_LPI_RCVD_BIT] = tx_lpi_rcvd_ff;
    pcs_sts_val[STS_RX_LPI_RCVD_BIT] = rx_lpi_rcvd_ff;
    pcs_sts_val[STS_TX_LPI_IND_BIT] = stat_i.tx_lpi; // RQ11
    pcs_sts_val[STS_RX_LPI_IND_BIT] = stat_i.rx_lpi; // RQ11
    pcs_sts_val[STS_TXCLK_STOP_BIT] = stat_i.txclk_stoppable; // RQ12
    cap_val = CAP_RESET;
    cap_val[CAP_100_BIT] = CAP_100_SUPPORT; // RQ13
    cap_val[CAP_1000_BIT] = CAP_1000_SUPPORT; // RQ13
  end

  always_comb begin
    nxt_rdata = ZERO16;
    if (req_i.rd) begin
      case (req_i.addr)
        ADDR_EEE_CONFIG_TWO: nxt_rdata = cfg2_ff; // RQ17
        ADDR_EEE_CONFIG_THREE: nxt_rdata = cfg3_ff;
        ADDR_PCS_CONTROL_ONE: nxt_rdata = pcs_ctrl_val;
        ADDR_PCS_STATUS_ONE: nxt_rdata = pcs_sts_val;
        ADDR_EEE_CAPABILITY: nxt_rdata = cap_val;
        ADDR_WAKE_ERROR_COUNT: nxt_rdata = wake_cnt_ff;
        ADDR_ADV_OVERRIDE: nxt_rdata = {14'h0000, adv_100_ff, 1'b0};
        ADDR_LP_ABILITY: nxt_rdata = {14'h0000, stat_i.lp_eee_100, 1'b0};
        default: nxt_rdata = ZERO16;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_ff <= ZERO16;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata_o = rdata_ff;

  // negotiated eee ability toward auto-negotiation
  always_comb begin
    if (cfg3_ff[CFG3_BYPASS_BIT]) begin
      neg_eee_100_o = cfg3_ff[CFG3_CAP_EN_BIT]; // RQ1 RQ2
    end else if (cfg3_ff[CFG3_CAP_EN_BIT]) begin
      neg_eee_100_o = cap_val[CAP_100_BIT] && adv_100_ff && stat_i.lp_eee_100; // RQ1 RQ5
    end else begin
      neg_eee_100_o = 1'b0; // RQ6
    end
  end

  always_comb begin
    ctrl_o.adv_eee_100 = cfg3_ff[CFG3_BYPASS_BIT] ? cfg3_ff[CFG3_CAP_EN_BIT]
                                                  : (cfg3_ff[CFG3_CAP_EN_BIT] && adv_100_ff); // RQ2
    ctrl_o.np_rx_disable = cfg3_ff[CFG3_NP_DIS_BIT]; // RQ3
    ctrl_o.rx_shutdown_en = cfg3_ff[CFG3_RX_SHUT_BIT]; // RQ4
    ctrl_o.rx_clk_stop_en = rx_clk_stop_ff; // RQ9
    ctrl_o.txer_lpi_req = cfg2_ff[CFG2_TXER_LPI_BIT];
    ctrl_o.txer_pin_sel = cfg2_ff[CFG2_PINSEL_LSB +: 2];
    ctrl_o.pcs_soft_reset = soft_rst_ff; // RQ7 RQ8
  end
endmodule
`default_nettype wire

// ==== eeecr_pkg.sv ====
// package for the energy-efficient-ethernet configuration and status register bank
package eeecr_pkg;
  localparam int EEECR_AW = 16;
  localparam int EEECR_DW = 16;

  // register addresses (16-bit word addresses on the plain port)
  localparam logic [15:0] ADDR_EEE_CONFIG_TWO = 16'h04D0;
  localparam logic [15:0] ADDR_EEE_CONFIG_THREE = 16'h04D1;
  localparam logic [15:0] ADDR_PCS_CONTROL_ONE = 16'h3000;
  localparam logic [15:0] ADDR_PCS_STATUS_ONE = 16'h3001;
  localparam logic [15:0] ADDR_EEE_CAPABILITY = 16'h3014;
  localparam logic [15:0] ADDR_WAKE_ERROR_COUNT = 16'h3016;
  localparam logic [15:0] ADDR_ADV_OVERRIDE = 16'h703C;
  localparam logic [15:0] ADDR_LP_ABILITY = 16'h703D;

  // eee_config_two fields
  localparam int CFG2_TXER_LPI_BIT = 14;
  localparam int CFG2_PINSEL_LSB = 5;
  localparam logic [15:0] CFG2_RESET = 16'h0182;
  localparam logic [15:0] CFG2_RW_MASK = 16'h4060;

  // eee_config_three fields
  localparam int CFG3_BYPASS_BIT = 3;
  localparam int CFG3_NP_DIS_BIT = 2;
  localparam int CFG3_RX_SHUT_BIT = 1;
  localparam int CFG3_CAP_EN_BIT = 0;
  localparam logic [15:0] CFG3_RESET = 16'h018A;

  // pcs_control_one fields
  localparam int PCS_RESET_BIT = 15;
  localparam int PCS_RXCLK_STOP_BIT = 10;
  localparam logic [15:0] PCS_CTRL_RESET = 16'h0000;

  // pcs_status_one fields
  localparam int STS_TX_LPI_RCVD_BIT = 11;
  localparam int STS_RX_LPI_RCVD_BIT = 10;
  localparam int STS_TX_LPI_IND_BIT = 9;
  localparam int STS_RX_LPI_IND_BIT = 8;
  localparam int STS_TXCLK_STOP_BIT = 6;

  // eee_capability fields
  localparam int CAP_100_BIT = 1;
  localparam int CAP_1000_BIT = 2;
  localparam logic [15:0] CAP_RESET = 16'h0000;

  // advertisement register (mmd7) field
  localparam int ADV_100_BIT = 1;
  localparam logic [15:0] ADV_RESET = 16'h0002;

  localparam logic [15:0] WAKE_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] ZERO16 = 16'h0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [EEECR_AW-1:0] addr;
    logic [EEECR_DW-1:0] wdata;
  } eeecr_req_s;

  // events and levels from the lpi state machines
  typedef struct packed {
    logic tx_lpi;
    logic rx_lpi;
    logic wake_fault;
    logic lp_eee_100;
    logic txclk_stoppable;
  } eeecr_stat_s;

  // controls steering the negotiation and lpi logic
  typedef struct packed {
    logic adv_eee_100;
    logic np_rx_disable;
    logic rx_shutdown_en;
    logic rx_clk_stop_en;
    logic txer_lpi_req;
    logic [1:0] txer_pin_sel;
    logic pcs_soft_reset;
  } eeecr_ctrl_s;
endpackage

// ==== eeecr_sva.sv ====
// assertions on the ports of the eee register bank
`default_nettype none
module eeecr_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic strap_eee_en_i,
  input wire eeecr_pkg::eeecr_req_s req_i,
  input wire eeecr_pkg::eeecr_stat_s stat_i,
  input wire logic [eeecr_pkg::EEECR_DW-1:0] rdata_o,
  input wire eeecr_pkg::eeecr_ctrl_s ctrl_o,
  input wire logic neg_eee_100_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import eeecr_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  wire logic w3 = req_i.wr && req_i.addr == ADDR_EEE_CONFIG_THREE;
  wire logic wp = req_i.wr && req_i.addr == ADDR_PCS_CONTROL_ONE;
  // a fault in the read cycle would leave a count of one, so it is excluded
  wire logic rc = req_i.rd && req_i.addr == ADDR_WAKE_ERROR_COUNT && !stat_i.wake_fault;
  a_soft_reset_pulse: assert property (wp && req_i.wdata[15] |=> ctrl_o.pcs_soft_reset && !ctrl_o.rx_clk_stop_en)
    else $error("soft reset pulse missing");
  a_rxclk_follow: assert property (wp && !req_i.wdata[15] |=> ctrl_o.rx_clk_stop_en == $past(req_i.wdata[10]))
    else $error("rx clock stop bit wrong");
  a_np_follow: assert property (w3 |=> ctrl_o.np_rx_disable == $past(req_i.wdata[2]))
    else $error("next page disable wrong");
  a_shutdown_follow: assert property (w3 |=> ctrl_o.rx_shutdown_en == $past(req_i.wdata[1]))
    else $error("rx shutdown wrong");
  a_bypass_ability: assert property (w3 && req_i.wdata[3] |=> neg_eee_100_o == $past(req_i.wdata[0]))
    else $error("bypass ability wrong");
  a_capen_off: assert property (w3 && !req_i.wdata[3] && !req_i.wdata[0] |=> !neg_eee_100_o)
    else $error("ability without enable");
  a_live_status: assert property (req_i.rd && req_i.addr == ADDR_PCS_STATUS_ONE |=>
    rdata_o[9:8] == $past({stat_i.tx_lpi, stat_i.rx_lpi}) && rdata_o[6] == $past(stat_i.txclk_stoppable))
    else $error("live status wrong");
  a_count_cleared: assert property (rc ##2 rc |=> rdata_o == ZERO16)
    else $error("counter not cleared by read");
  c_soft_reset: cover property (wp && req_i.wdata[15]);
  c_two_reads: cover property (rc ##2 rc);
  c_no_bypass: cover property (w3 && !req_i.wdata[3]);
endmodule
bind eeecr_regs eeecr_sva u_sva (.clk_i(clk_i), .reset_i(reset_i), .strap_eee_en_i(strap_eee_en_i),
  .req_i(req_i), .stat_i(stat_i), .rdata_o(rdata_o), .ctrl_o(ctrl_o), .neg_eee_100_o(neg_eee_100_o));
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the eee register bank
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import eeecr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic strap = 1'b1;
  eeecr_req_s req = '0;
  eeecr_stat_s stat = '0;
  logic [15:0] rdata;
  eeecr_ctrl_s ctrl;
  logic neg;
  int n_errors = 0;
  int check_count = 0;
  always #2.5 clk_i = ~clk_i;
  // 100 Mb support on so that the non-bypass ability path can become true
  eeecr_regs #(.CAP_100_SUPPORT(1'b1)) DUT (.clk_i(clk_i), .reset_i(reset_i), .strap_eee_en_i(strap),
    .req_i(req), .stat_i(stat), .rdata_o(rdata), .ctrl_o(ctrl), .neg_eee_100_o(neg));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask
  task automatic fault(input int n);
    @(posedge clk_i);
    stat.wake_fault <= 1'b1;
    repeat (n) @(posedge clk_i);
    stat.wake_fault <= 1'b0;
  endtask
  task automatic t_reset();
    rd(ADDR_EEE_CONFIG_TWO, CFG2_RESET);
    rd(ADDR_EEE_CONFIG_THREE, 16'h018B);
    rd(ADDR_EEE_CAPABILITY, 16'h0002);
    rd(16'h1234, 16'h0000);
    chk("neg", neg, 16'h0001);
    $display("t_reset done");
  endtask
  task automatic t_cfg();
    logic [4:0] j;
    wr(ADDR_EEE_CONFIG_TWO, 16'hFFFF);
    rd(ADDR_EEE_CONFIG_TWO, 16'h41E2);
    chk("txer_lpi", ctrl.txer_lpi_req, 16'h0001);
    chk("txer_pin", ctrl.txer_pin_sel, 16'h0003);
    for (int k = 0; k < 32; k++) begin
      j = k[4:0];
      @(posedge clk_i);
      stat.lp_eee_100 <= j[4];
      wr(ADDR_EEE_CONFIG_THREE, {12'h018, j[3:0]});
      chk("np", ctrl.np_rx_disable, j[2]);
      chk("shut", ctrl.rx_shutdown_en, j[1]);
      chk("neg", neg, j[3] ? j[0] : j[0] & j[4]);
      chk("adv", ctrl.adv_eee_100, j[0]);
    end
    wr(ADDR_EEE_CONFIG_THREE, 16'h0181);
    wr(ADDR_ADV_OVERRIDE, 16'h0000);
    chk("neg", neg, 16'h0000);
    $display("t_cfg done");
  endtask
  task automatic t_status();
    @(posedge clk_i);
    stat <= '{tx_lpi: 1'b1, txclk_stoppable: 1'b1, lp_eee_100: 1'b1, default: 1'b0};
    rd(ADDR_PCS_STATUS_ONE, 16'h0A40);
    @(posedge clk_i);
    stat <= '{rx_lpi: 1'b1, lp_eee_100: 1'b1, default: 1'b0};
    rd(ADDR_PCS_STATUS_ONE, 16'h0D00);
    @(posedge clk_i);
    stat.rx_lpi <= 1'b0;
    rd(ADDR_PCS_STATUS_ONE, 16'h0C00);
    $display("t_status done");
  endtask
  task automatic t_wake();
    repeat (3) fault(1);
    rd(ADDR_WAKE_ERROR_COUNT, 16'h0003);
    rd(ADDR_WAKE_ERROR_COUNT, 16'h0000);
    fault(65540);
    rd(ADDR_WAKE_ERROR_COUNT, WAKE_CNT_MAX);
    rd(ADDR_WAKE_ERROR_COUNT, 16'h0000);
    $display("t_wake done");
  endtask
  task automatic t_pcs();
    wr(ADDR_PCS_CONTROL_ONE, 16'h7FFF);
    rd(ADDR_PCS_CONTROL_ONE, 16'h0400);
    chk("rxclk", ctrl.rx_clk_stop_en, 16'h0001);
    fault(2);
    wr(ADDR_PCS_CONTROL_ONE, 16'h8000);
    chk("pulse", ctrl.pcs_soft_reset, 16'h0001);
    rd(ADDR_PCS_CONTROL_ONE, 16'h0000);
    rd(ADDR_WAKE_ERROR_COUNT, 16'h0000);
    rd(ADDR_PCS_STATUS_ONE, 16'h0000);
    rd(ADDR_ADV_OVERRIDE, ADV_RESET);
    rd(ADDR_EEE_CONFIG_THREE, 16'h0181);
    chk("neg", neg, 16'h0001);
    $display("t_pcs done");
  endtask
  // mid-run reset with the strap low: capabilities-enable must come up cleared
  task automatic t_strap();
    @(posedge clk_i);
    strap <= 1'b0;
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(ADDR_EEE_CONFIG_THREE, 16'h018A);
    chk("neg", neg, 16'h0000);
    rd(ADDR_WAKE_ERROR_COUNT, 16'h0000);
    $display("t_strap done");
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_cfg();
    t_status();
    t_wake();
    t_pcs();
    t_strap();
    finish_test();
  end
endmodule
`default_nettype wire
